// ==== sltlc_top.sv ====
// transmit lane control: registers, alignment characters, lane crossbar, output stage
`timescale 1ns/100ps
module sltlc_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [sltlc_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic PLL_LOCKED_I,
    input wire logic PHASE_ESTABLISHED_I,
    input wire logic SYNC_REQUEST_INPUT_A_I,
    input wire logic SYNC_REQUEST_INPUT_B_I,
    output logic SYNC_REQUEST_A_O,
    output logic SYNC_REQUEST_B_O,
    output logic [3:0] SYNC_INPUT_A_CFG_O,
    output logic [3:0] SYNC_INPUT_B_CFG_O,
    input wire logic [sltlc_pkg::DATA_W-1:0] LOGICAL_DATA_I,
    input wire logic FRAME_END_I,
    input wire logic MULTIFRAME_END_I,
    input wire logic [11:0] CRC_I,
    input wire logic IN_VALID_I,
    output logic IN_READY_O,
    output logic [sltlc_pkg::DATA_W-1:0] PHY_DATA_O,
    output logic [sltlc_pkg::NUM_LANES-1:0] PHY_K_CHAR_O,
    output logic [11:0] PHY_CRC_O,
    output logic PHY_VALID_O,
    input wire logic PHY_READY_I,
    output logic [1:0] LINK_LAYER_O,
    output logic SCRAMBLE_EN_O,
    output logic [7:0] EMB_SIZE_O,
    output logic [1:0] PAR_WIDTH_O,
    output logic [sltlc_pkg::NUM_LANES-1:0] LANE_PD_O,
    output logic [sltlc_pkg::NUM_LANES-1:0] SER_PD_O,
    output logic [23:0] POST_TAP_O,
    output logic [63:0] PRE_TAP_O
);
    import sltlc_pkg::*;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [1:0] link_sel_q, link_sel_d;
    logic scr_en_q, scr_en_d;
    logic acg_byp_q, acg_byp_d;
    logic lsync_q, lsync_d;
    logic crc_rev_q, crc_rev_d;
    logic [7:0] emb_size_q, emb_size_d;
    logic [7:0] ser_pd_q, ser_pd_d;
    logic [1:0] par_width_q, par_width_d;
    logic [3:0] sync_a_cfg_q, sync_a_cfg_d;
    logic [3:0] sync_b_cfg_q, sync_b_cfg_d;
    logic [NUM_LANES-1:0] force_q, force_d;
    logic [NUM_LANES-1:0] inv_q, inv_d;
    logic [4:0] assign_q [NUM_LANES], assign_d [NUM_LANES];
    logic [2:0] post_tap_q [NUM_LANES], post_tap_d [NUM_LANES];
    logic [7:0] pre_tap_q [NUM_LANES], pre_tap_d [NUM_LANES];
    logic pll_q, pll_d, phase_q, phase_d;
    logic sync_a_q, sync_a_d, sync_b_q, sync_b_d;
    logic [NUM_LANES-1:0] lane_down_q, lane_down_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        link_sel_d = link_sel_q;
        scr_en_d = scr_en_q;
        acg_byp_d = acg_byp_q;
        lsync_d = lsync_q;
        crc_rev_d = crc_rev_q;
        emb_size_d = emb_size_q;
        ser_pd_d = ser_pd_q;
        par_width_d = par_width_q;
        sync_a_cfg_d = sync_a_cfg_q;
        sync_b_cfg_d = sync_b_cfg_q;
        force_d = force_q;
        inv_d = inv_q;
        assign_d = assign_q;
        post_tap_d = post_tap_q;
        pre_tap_d = pre_tap_q;
        pll_d = PLL_LOCKED_I;
        phase_d = PHASE_ESTABLISHED_I;
        // a powered-down receiver reads as no request (idle high)
        sync_a_d = sync_a_cfg_q[SYNC_PD_BIT] ? 1'b1 :
            (SYNC_REQUEST_INPUT_A_I ^ sync_a_cfg_q[SYNC_INV_BIT]);
        sync_b_d = sync_b_cfg_q[SYNC_PD_BIT] ? 1'b1 :
            (SYNC_REQUEST_INPUT_B_I ^ sync_b_cfg_q[SYNC_INV_BIT]);
        rdata_d = rdata_q;
        for (int p = 0; p < NUM_LANES; p++) begin
            // a lane is down when forced off or fed from no existing logical lane
            lane_down_d[p] = force_q[p] | (assign_q[p] >= 5'(NUM_LANES));
        end
        if (REG_WR_I) begin
            // invalid link layer and block size codes are stored as written
            unique case (REG_ADDR_I)
                OFS_LINK_LAYER_SELECT: link_sel_d = REG_WDATA_I[LINK_SEL_LSB +: 2];
                OFS_SCRAMBLER_ENABLE: scr_en_d = REG_WDATA_I[SCR_EN_BIT];
                OFS_ALIGNMENT_CHAR_BYPASS: acg_byp_d = REG_WDATA_I[ACG_BYP_BIT];
                OFS_LANE_SYNC_CHAR_INSERT: lsync_d = REG_WDATA_I[LSYNC_BIT];
                OFS_CRC_BIT_ORDER: crc_rev_d = REG_WDATA_I[CRC_REV_BIT];
                OFS_EXTENDED_MULTIBLOCK_SIZE: emb_size_d = REG_WDATA_I;
                OFS_SERIALIZER_POWER_DOWN: ser_pd_d = REG_WDATA_I;
                OFS_PARALLEL_WIDTH_SELECT: par_width_d = REG_WDATA_I[1:0];
                OFS_SYNC_INPUT_A_CONFIG: sync_a_cfg_d = REG_WDATA_I[3:0];
                OFS_SYNC_INPUT_B_CONFIG: sync_b_cfg_d = REG_WDATA_I[3:0];
                default: ;
            endcase
            for (int p = 0; p < NUM_LANES; p++) begin
                if (REG_ADDR_I == OFS_LANE0_CONTROL_STATUS + 12'(p)) begin
                    force_d[p] = REG_WDATA_I[LANE_FORCE_BIT];
                    inv_d[p] = REG_WDATA_I[LANE_INV_BIT];
                    assign_d[p] = REG_WDATA_I[4:0];
                end
                if (REG_ADDR_I == OFS_PRE_TAP_FIRST + 12'(p)) begin
                    pre_tap_d[p] = REG_WDATA_I;
                end
                // two lanes share each post-tap register: even low, odd high
                if (REG_ADDR_I == OFS_POST_TAP_FIRST + 12'(p / 2)) begin
                    post_tap_d[p] = (p % 2 == 1) ? REG_WDATA_I[6:4] : REG_WDATA_I[2:0];
                end
            end
        end
        if (REG_RD_I) begin
            rdata_d = 8'h00;
            unique case (REG_ADDR_I)
                OFS_LINK_LAYER_SELECT: rdata_d[LINK_SEL_LSB +: 2] = link_sel_q;
                OFS_SCRAMBLER_ENABLE: rdata_d[SCR_EN_BIT] = scr_en_q;
                OFS_ALIGNMENT_CHAR_BYPASS: rdata_d[ACG_BYP_BIT] = acg_byp_q;
                OFS_LANE_SYNC_CHAR_INSERT: rdata_d[LSYNC_BIT] = lsync_q;
                OFS_CRC_BIT_ORDER: rdata_d[CRC_REV_BIT] = crc_rev_q;
                OFS_EXTENDED_MULTIBLOCK_SIZE: rdata_d = emb_size_q;
                OFS_TX_PLL_LOCK_STATUS: rdata_d[PLL_LOCK_BIT] = pll_q;
                OFS_TX_PHASE_STATUS: rdata_d[PHASE_BIT] = phase_q;
                OFS_SERIALIZER_POWER_DOWN: rdata_d = ser_pd_q;
                OFS_PARALLEL_WIDTH_SELECT: rdata_d[1:0] = par_width_q;
                OFS_SYNC_INPUT_A_CONFIG: rdata_d[3:0] = sync_a_cfg_q;
                OFS_SYNC_INPUT_B_CONFIG: rdata_d[3:0] = sync_b_cfg_q;
                default: ;
            endcase
            for (int p = 0; p < NUM_LANES; p++) begin
                if (REG_ADDR_I == OFS_LANE0_CONTROL_STATUS + 12'(p)) begin
                    rdata_d = {lane_down_q[p], force_q[p], inv_q[p], assign_q[p]};
                end
                if (REG_ADDR_I == OFS_PRE_TAP_FIRST + 12'(p)) begin
                    rdata_d = pre_tap_q[p];
                end
                if (REG_ADDR_I == OFS_POST_TAP_FIRST + 12'(p / 2)) begin
                    if (p % 2 == 1) begin
                        rdata_d[6:4] = post_tap_q[p];
                    end else begin
                        rdata_d[2:0] = post_tap_q[p];
                    end
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            link_sel_q <= RST_LINK_SEL;
            scr_en_q <= 1'b0;
            acg_byp_q <= 1'b0;
            lsync_q <= 1'b0;
            crc_rev_q <= 1'b0;
            emb_size_q <= RST_EMB_SIZE;
            ser_pd_q <= RST_SER_PD;
            par_width_q <= RST_PAR_WIDTH;
            sync_a_cfg_q <= RST_SYNC_CFG;
            sync_b_cfg_q <= RST_SYNC_CFG;
            force_q <= '0;
            inv_q <= '0;
            for (int p = 0; p < NUM_LANES; p++) begin
                assign_q[p] <= 5'(p);
                post_tap_q[p] <= RST_POST_TAP;
                pre_tap_q[p] <= RST_PRE_TAP;
            end
            pll_q <= 1'b0;
            phase_q <= 1'b0;
            sync_a_q <= 1'b1;
            sync_b_q <= 1'b1;
            lane_down_q <= '0;
            rdata_q <= 8'h00;
        end else begin
            link_sel_q <= link_sel_d;
            scr_en_q <= scr_en_d;
            acg_byp_q <= acg_byp_d;
            lsync_q <= lsync_d;
            crc_rev_q <= crc_rev_d;
            emb_size_q <= emb_size_d;
            ser_pd_q <= ser_pd_d;
            par_width_q <= par_width_d;
            sync_a_cfg_q <= sync_a_cfg_d;
            sync_b_cfg_q <= sync_b_cfg_d;
            force_q <= force_d;
            inv_q <= inv_d;
            assign_q <= assign_d;
            post_tap_q <= post_tap_d;
            pre_tap_q <= pre_tap_d;
            pll_q <= pll_d;
            phase_q <= phase_d;
            sync_a_q <= sync_a_d;
            sync_b_q <= sync_b_d;
            lane_down_q <= lane_down_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // alignment characters and lane crossbar
    // ----------------------------------------------------------------
    logic [LANE_W-1:0] lw [NUM_LANES];
    logic [NUM_LANES-1:0] lk;
    logic [DATA_W-1:0] xb_data;
    logic [NUM_LANES-1:0] xb_k;
    logic [11:0] crc_fix;
    logic [7:0] prev_q [NUM_LANES], prev_d [NUM_LANES];
    logic accept;
    logic in_ready_q;

    assign accept = IN_VALID_I & in_ready_q;

    always_comb begin
        logic [7:0] last;
        logic mk_f;
        logic mk_a;
        last = 8'h00;
        mk_f = 1'b0;
        mk_a = 1'b0;
        prev_d = prev_q;
        xb_data = '0;
        xb_k = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
            lw[i] = LOGICAL_DATA_I[i*LANE_W +: LANE_W];
            last = lw[i][LAST_OCTET_LSB +: 8];
            mk_f = 1'b0;
            mk_a = 1'b0;
            if (link_sel_q == LL_8B10B && !acg_byp_q && FRAME_END_I) begin
                if (scr_en_q) begin
                    mk_a = MULTIFRAME_END_I && lsync_q && last == CHAR_K28_3;
                    mk_f = !mk_a && last == CHAR_K28_7;
                end else if (last == prev_q[i]) begin
                    mk_a = MULTIFRAME_END_I && lsync_q;
                    mk_f = !mk_a;
                end
            end
            if (mk_a) begin
                lw[i][LAST_OCTET_LSB +: 8] = CHAR_K28_3;
            end else if (mk_f) begin
                lw[i][LAST_OCTET_LSB +: 8] = CHAR_K28_7;
            end
            lk[i] = mk_a | mk_f;
            if (accept && FRAME_END_I) begin
                prev_d[i] = last;
            end
        end
        for (int p = 0; p < NUM_LANES; p++) begin
            // forced-off or unsourced lanes transmit zeros
            if (!force_q[p] && assign_q[p] < 5'(NUM_LANES)) begin
                xb_data[p*LANE_W +: LANE_W] = lw[assign_q[p][2:0]] ^ {LANE_W{inv_q[p]}};
                xb_k[p] = lk[assign_q[p][2:0]];
            end
        end
        crc_fix = CRC_I;
        if (link_sel_q == LL_64B66B && crc_rev_q) begin
            for (int b = 0; b < 12; b++) begin
                crc_fix[b] = CRC_I[11-b];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            prev_q <= '{default: 8'h00};
        end else begin
            prev_q <= prev_d;
        end
    end

    // ----------------------------------------------------------------
    // two-entry output stage
    // ----------------------------------------------------------------
    // the sync inputs never gate this path: data keeps flowing while the
    // receiver resynchronises, only back-pressure from the phy stalls it
    logic out_valid_q, out_valid_d;
    logic [DATA_W-1:0] out_data_q, out_data_d;
    logic [NUM_LANES-1:0] out_k_q, out_k_d;
    logic [11:0] out_crc_q, out_crc_d;
    logic skid_valid_q, skid_valid_d;
    logic [DATA_W-1:0] skid_data_q, skid_data_d;
    logic [NUM_LANES-1:0] skid_k_q, skid_k_d;
    logic [11:0] skid_crc_q, skid_crc_d;

    always_comb begin
        out_valid_d = out_valid_q;
        out_data_d = out_data_q;
        out_k_d = out_k_q;
        out_crc_d = out_crc_q;
        skid_valid_d = skid_valid_q;
        skid_data_d = skid_data_q;
        skid_k_d = skid_k_q;
        skid_crc_d = skid_crc_q;
        if (PHY_READY_I || !out_valid_q) begin
            if (skid_valid_q) begin
                out_valid_d = 1'b1;
                out_data_d = skid_data_q;
                out_k_d = skid_k_q;
                out_crc_d = skid_crc_q;
                skid_valid_d = 1'b0;
            end else begin
                out_valid_d = accept;
                if (accept) begin
                    out_data_d = xb_data;
                    out_k_d = xb_k;
                    out_crc_d = crc_fix;
                end
            end
        end else if (accept) begin
            skid_valid_d = 1'b1;
            skid_data_d = xb_data;
            skid_k_d = xb_k;
            skid_crc_d = crc_fix;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
            out_k_q <= '0;
            out_crc_q <= 12'h000;
            skid_valid_q <= 1'b0;
            skid_data_q <= '0;
            skid_k_q <= '0;
            skid_crc_q <= 12'h000;
            in_ready_q <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            out_data_q <= out_data_d;
            out_k_q <= out_k_d;
            out_crc_q <= out_crc_d;
            skid_valid_q <= skid_valid_d;
            skid_data_q <= skid_data_d;
            skid_k_q <= skid_k_d;
            skid_crc_q <= skid_crc_d;
            in_ready_q <= !skid_valid_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign REG_RDATA_O = rdata_q;
    assign SYNC_REQUEST_A_O = sync_a_q;
    assign SYNC_REQUEST_B_O = sync_b_q;
    assign SYNC_INPUT_A_CFG_O = sync_a_cfg_q;
    assign SYNC_INPUT_B_CFG_O = sync_b_cfg_q;
    assign IN_READY_O = in_ready_q;
    assign PHY_DATA_O = out_data_q;
    assign PHY_K_CHAR_O = out_k_q;
    assign PHY_CRC_O = out_crc_q;
    assign PHY_VALID_O = out_valid_q;
    assign LINK_LAYER_O = link_sel_q;
    assign SCRAMBLE_EN_O = scr_en_q;
    assign EMB_SIZE_O = emb_size_q;
    assign PAR_WIDTH_O = par_width_q;
    assign LANE_PD_O = lane_down_q;
    assign SER_PD_O = ser_pd_q;
    assign POST_TAP_O = {post_tap_q[7], post_tap_q[6], post_tap_q[5], post_tap_q[4],
        post_tap_q[3], post_tap_q[2], post_tap_q[1], post_tap_q[0]};
    assign PRE_TAP_O = {pre_tap_q[7], pre_tap_q[6], pre_tap_q[5], pre_tap_q[4],
        pre_tap_q[3], pre_tap_q[2], pre_tap_q[1], pre_tap_q[0]};

endmodule

// ==== sltlc_pkg.sv ====
// constants, offsets and types for the transmit lane control block
package sltlc_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_LANES = 8;
    localparam int LANE_W = 66;
    localparam int DATA_W = NUM_LANES * LANE_W;
    localparam int ADDR_W = 12;
    localparam int LAST_OCTET_LSB = 24;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_LINK_LAYER_SELECT = 12'h611;
    localparam logic [11:0] OFS_LANE0_CONTROL_STATUS = 12'h61B;
    localparam logic [11:0] OFS_LANE7_CONTROL_STATUS = 12'h622;
    localparam logic [11:0] OFS_SCRAMBLER_ENABLE = 12'h63D;
    localparam logic [11:0] OFS_ALIGNMENT_CHAR_BYPASS = 12'h659;
    localparam logic [11:0] OFS_LANE_SYNC_CHAR_INSERT = 12'h65A;
    localparam logic [11:0] OFS_CRC_BIT_ORDER = 12'h667;
    localparam logic [11:0] OFS_EXTENDED_MULTIBLOCK_SIZE = 12'h668;
    localparam logic [11:0] OFS_TX_PLL_LOCK_STATUS = 12'h701;
    localparam logic [11:0] OFS_TX_PHASE_STATUS = 12'h713;
    localparam logic [11:0] OFS_SERIALIZER_POWER_DOWN = 12'h750;
    localparam logic [11:0] OFS_POST_TAP_FIRST = 12'h75A;
    localparam logic [11:0] OFS_POST_TAP_LAST = 12'h75D;
    localparam logic [11:0] OFS_PARALLEL_WIDTH_SELECT = 12'h762;
    localparam logic [11:0] OFS_PRE_TAP_FIRST = 12'h763;
    localparam logic [11:0] OFS_PRE_TAP_LAST = 12'h76A;
    localparam logic [11:0] OFS_SYNC_INPUT_A_CONFIG = 12'h797;
    localparam logic [11:0] OFS_SYNC_INPUT_B_CONFIG = 12'h798;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int LINK_SEL_LSB = 4;
    localparam int SCR_EN_BIT = 7;
    localparam int ACG_BYP_BIT = 0;
    localparam int LSYNC_BIT = 2;
    localparam int CRC_REV_BIT = 0;
    localparam int PLL_LOCK_BIT = 7;
    localparam int PHASE_BIT = 0;
    localparam int LANE_PD_STAT_BIT = 7;
    localparam int LANE_FORCE_BIT = 6;
    localparam int LANE_INV_BIT = 5;
    localparam int SYNC_PD_BIT = 3;
    localparam int SYNC_INV_BIT = 2;
    localparam int SYNC_TERM_BIT = 1;
    localparam int SYNC_MODE_BIT = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_LINK_SEL = 2'h0;
    localparam logic [7:0] RST_EMB_SIZE = 8'h00;
    localparam logic [7:0] RST_SER_PD = 8'hFF;
    localparam logic [1:0] RST_PAR_WIDTH = 2'h1;
    localparam logic [3:0] RST_SYNC_CFG = 4'h8;
    localparam logic [2:0] RST_POST_TAP = 3'h0;
    localparam logic [7:0] RST_PRE_TAP = 8'h00;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LL_8B10B = 2'h0,
        LL_64B66B = 2'h1
    } sltlc_layer_t;

    localparam logic [1:0] PAR_66BIT = 2'h0;
    localparam logic [1:0] PAR_40BIT = 2'h1;
    localparam logic [7:0] CHAR_K28_7 = 8'hFC;
    localparam logic [7:0] CHAR_K28_3 = 8'h7C;

endpackage

// ==== sltlc_chk_sva.sv ====
// concurrent checks on the transmit lane control ports
`timescale 1ns/100ps
module sltlc_chk (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [sltlc_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic PLL_LOCKED_I,
    input wire logic [sltlc_pkg::DATA_W-1:0] PHY_DATA_O,
    input wire logic PHY_VALID_O,
    input wire logic PHY_READY_I,
    input wire logic [1:0] LINK_LAYER_O,
    input wire logic SCRAMBLE_EN_O,
    input wire logic [7:0] SER_PD_O,
    input wire logic [3:0] SYNC_INPUT_A_CFG_O
);
    import sltlc_pkg::*;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [7:0] wd_d, wd_q;
    always_comb wd_d = REG_WDATA_I;
    always_ff @(posedge CORE_CLK_I) wd_q <= wd_d;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_wr(logic [11:0] a);
        REG_WR_I && REG_ADDR_I == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        REG_RD_I && REG_ADDR_I == a;
    endsequence
    a_reset_values: assert property ($rose(RST_B_I) |-> SER_PD_O == 8'hFF
        && LINK_LAYER_O == 2'h0 && !SCRAMBLE_EN_O && SYNC_INPUT_A_CFG_O == 4'h8)
        else $error("outputs not at reset values");
    a_link_copy: assert property (s_wr(OFS_LINK_LAYER_SELECT) |=> LINK_LAYER_O == wd_q[5:4])
        else $error("link layer not updated");
    a_scr_copy: assert property (s_wr(OFS_SCRAMBLER_ENABLE) |=> SCRAMBLE_EN_O == wd_q[7])
        else $error("scrambler enable not updated");
    a_ser_copy: assert property (s_wr(OFS_SERIALIZER_POWER_DOWN) |=> SER_PD_O == wd_q)
        else $error("serializer power not updated");
    a_sync_copy: assert property (s_wr(OFS_SYNC_INPUT_A_CONFIG)
        |=> SYNC_INPUT_A_CFG_O == wd_q[3:0]) else $error("sync input config not updated");
    a_unmapped_zero: assert property (s_rd(12'h7FF) |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    a_pll_read: assert property (s_rd(OFS_TX_PLL_LOCK_STATUS) ##0 $past(RST_B_I)
        |=> REG_RDATA_O == {$past(PLL_LOCKED_I, 2), 7'h00}) else $error("pll status wrong");
    a_stall_hold: assert property (PHY_VALID_O && !PHY_READY_I
        |=> PHY_VALID_O && $stable(PHY_DATA_O)) else $error("word dropped during stall");
endmodule

// ==== sltlc_phy_model.sv ====
// far-side phy model: takes words, stalling now and then
`timescale 1ns/100ps
module sltlc_phy_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    output logic ready_o
);
    int seed = 32'h44A5;
    // a stall about one cycle in four keeps the skid entry busy
    always @(posedge clk_i) ready_o <= rst_b_i && ($random(seed) % 4 != 0);
endmodule

// ==== serial_link_tx_lane_control_tb_top.sv ====
// self-checking bench for the transmit lane control block
`timescale 1ns/100ps
module serial_link_tx_lane_control_tb_top;
    import sltlc_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, pll = 0, ph = 0, sa = 1, vld = 0, fe = 0, b8 = 0;
    logic irdy, pvld, ready, sra;
    logic [11:0] addr = 0, crc = 0, pcrc;
    logic [7:0] wd = 0, v, rdata, kc, lpd, cfg [8], qk [$];
    logic [23:0] ptap;
    logic [63:0] prtap;
    logic [527:0] ld = 0, pdata;
    logic [543:0] r;
    logic [539:0] q [$];
    int seed = 32'h44A5, n_mismatch = 0, checked = 0, cyc = 0;
    logic [11:0] ra [10] = '{12'h611, 12'h63D, 12'h659, 12'h65A, 12'h667, 12'h668,
        12'h750, 12'h762, 12'h797, 12'h798};
    logic [7:0] rr [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h08, 8'h08};
    logic [7:0] rm [10] = '{8'h30, 8'h80, 8'h01, 8'h04, 8'h01, 8'hFF, 8'hFF, 8'h03, 8'h0F, 8'h0F};
    always #50 clk = ~clk;
    sltlc_top dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_WDATA_I(wd), .REG_RD_I(rd), .REG_RDATA_O(rdata), .PLL_LOCKED_I(pll),
        .PHASE_ESTABLISHED_I(ph), .SYNC_REQUEST_INPUT_A_I(sa), .SYNC_REQUEST_INPUT_B_I(sa),
        .SYNC_REQUEST_A_O(sra), .SYNC_REQUEST_B_O(), .SYNC_INPUT_A_CFG_O(),
        .SYNC_INPUT_B_CFG_O(), .LOGICAL_DATA_I(ld), .FRAME_END_I(fe), .MULTIFRAME_END_I(fe),
        .CRC_I(crc), .IN_VALID_I(vld), .IN_READY_O(irdy), .PHY_DATA_O(pdata),
        .PHY_K_CHAR_O(kc), .PHY_CRC_O(pcrc), .PHY_VALID_O(pvld), .PHY_READY_I(ready),
        .LINK_LAYER_O(), .SCRAMBLE_EN_O(), .EMB_SIZE_O(), .PAR_WIDTH_O(), .LANE_PD_O(lpd),
        .SER_PD_O(), .POST_TAP_O(ptap), .PRE_TAP_O(prtap));
    sltlc_phy_model u_phy (.clk_i(clk), .rst_b_i(rst_b), .ready_o(ready));
    task automatic chk(input string n, input logic [539:0] x, input logic [539:0] s);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), 540'(x), 540'(rdata));
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // lane crossbar: forced or out-of-range source sends zeros
    function automatic logic [539:0] expect_word(input logic [543:0] w);
        logic [527:0] d = '0;
        for (int p = 0; p < 8; p++)
            if (!cfg[p][6] && cfg[p][4:0] < 5'h08)
                d[p*66+:66] = w[cfg[p][2:0]*66+:66] ^ {66{cfg[p][5]}};
        for (int b = 0; b < 12; b++) expect_word[528+b] = b8 ? w[528+b] : w[539-b];
        expect_word[527:0] = d;
    endfunction
    // scrambled 8b/10b: a frame-end 0xFC or 0x7C goes out as its own k character
    function automatic logic [7:0] expect_k(input logic [543:0] w);
        logic [7:0] o;
        expect_k = '0;
        for (int p = 0; p < 8; p++) begin
            o = w[cfg[p][2:0]*66+24+:8];
            expect_k[p] = (o == 8'hFC || o == 8'h7C) && b8 && w[543];
            if (cfg[p][6] || cfg[p][4:0] >= 5'h08) expect_k[p] = 1'b0;
        end
    endfunction
    always @(negedge clk) if (pvld && ready) begin
        chk("phy word", q.pop_front(), {pcrc, pdata});
        chk("k chars", 540'(qk.pop_front()), 540'(kc));
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) rchk(ra[i], rr[i]);
        for (int p = 0; p < 8; p++) rchk(12'(OFS_LANE0_CONTROL_STATUS + p), 8'(p));
        rchk(OFS_TX_PLL_LOCK_STATUS, 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = 8'($random(seed));
            wreg(ra[i], v);
            rchk(ra[i], v & rm[i]);
        end
        wreg(12'h7FF, 8'hFF);
        rchk(12'h7FF, 8'h00);
        @(posedge clk);
        pll <= 1'b1;
        ph <= 1'b1;
        rchk(OFS_TX_PLL_LOCK_STATUS, 8'h80);
        rchk(OFS_TX_PHASE_STATUS, 8'h01);
        wreg(OFS_SYNC_INPUT_A_CONFIG, 8'h04);
        repeat (3) @(negedge clk);
        chk("sync a", 540'(0), 540'(sra));
        wreg(OFS_LINK_LAYER_SELECT, 8'h10);
        wreg(OFS_CRC_BIT_ORDER, 8'h01);
        wreg(OFS_SERIALIZER_POWER_DOWN, 8'h00);
        for (int p = 0; p < 8; p++) begin
            cfg[p] = 8'($random(seed)) & 8'h2F | (p == 7 ? 8'h40 : 8'h00);
            wreg(12'(OFS_LANE0_CONTROL_STATUS + p), cfg[p]);
        end
        for (int p = 0; p < 8; p++) begin
            rchk(12'(OFS_LANE0_CONTROL_STATUS + p), {cfg[p][6] | cfg[p][3], cfg[p][6:0]});
            chk("lane pd", 540'(cfg[p][6] | cfg[p][3]), 540'(lpd[p]));
        end
        wreg(12'(OFS_POST_TAP_FIRST + 1), 8'h21);
        wreg(12'(OFS_PRE_TAP_FIRST + 2), 8'h02);
        rchk(12'(OFS_POST_TAP_FIRST + 1), 8'h21);
        rchk(12'(OFS_PRE_TAP_FIRST + 2), 8'h02);
        chk("taps", 540'({24'h000440, 64'h0000_0000_0002_0000}), 540'({ptap, prtap}));
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                // scrambled 8b/10b with multiframe characters; crc is never reversed here
                wreg(OFS_LINK_LAYER_SELECT, 8'h00);
                wreg(OFS_ALIGNMENT_CHAR_BYPASS, 8'h00);
                wreg(OFS_LANE_SYNC_CHAR_INSERT, 8'h04);
                wreg(OFS_SCRAMBLER_ENABLE, 8'h80);
                b8 = 1'b1;
            end
            @(posedge clk);
            for (int n = 0; n < 60; n++) begin
                for (int k = 0; k < 17; k++) r[k*32+:32] = $random(seed);
                // corner case: alignment octets on logical lanes 0 and 1
                if (b8 && n % 2 == 0) begin
                    r[24+:8] = 8'hFC;
                    r[90+:8] = 8'h7C;
                end
                ld <= r[527:0];
                crc <= r[539:528];
                fe <= r[543];
                vld <= 1'b1;
                q.push_back(expect_word(r));
                qk.push_back(expect_k(r));
                @(negedge clk);
                while (!irdy) @(negedge clk);
                @(posedge clk);
            end
            vld <= 1'b0;
            repeat (20) @(negedge clk);
            chk("words left", 540'(0), 540'(q.size()));
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) rchk(ra[i], rr[i]);
        close_out();
    end
endmodule
bind sltlc_top sltlc_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .PLL_LOCKED_I(PLL_LOCKED_I),
    .PHY_DATA_O(PHY_DATA_O), .PHY_VALID_O(PHY_VALID_O), .PHY_READY_I(PHY_READY_I),
    .LINK_LAYER_O(LINK_LAYER_O), .SCRAMBLE_EN_O(SCRAMBLE_EN_O), .SER_PD_O(SER_PD_O),
    .SYNC_INPUT_A_CFG_O(SYNC_INPUT_A_CFG_O));
